// File: rtl/pcmp_top.sv
// Position compare pulse output with a classic Wishbone register port.
// Assumes pos_actual and pos_valid come from encoder logic on sys_clk.
`timescale 1ns/1ps
module pcmp_top
  import pcmp_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               arst_n,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic               pos_valid,
  input  wire logic signed [31:0] pos_actual,
  output logic [NUM_OUT-1:0]      compare_pulse_output
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic                      ack;
    logic [31:0]               rdata;
    logic                      inhibit;
    pcmp_dir_t                 dir;
    logic [31:0]               width;
    logic [15:0]               comp;
    logic [31:0]               route;
    logic [NUM_CMP-1:0][31:0]  cmp;
    logic [31:0]               prev_pos;
    logic [31:0]               speed;
    logic [31:0]               pred;
    logic                      pred_valid;
    logic                      primed;
  } pcmp_top_t;

  pcmp_top_t s;
  pcmp_top_t next_s;

  logic                            access;
  logic [7:0]                      word_adr;
  logic                            cmp_hit;
  logic [2:0]                      cmp_idx;
  logic [31:0]                     rd_mux;
  logic signed [16:0]              lead;
  logic signed [48:0]              prod;
  logic signed [48:0]              corr;
  logic [NUM_CMP-1:0]              hit;
  logic [NUM_OUT-1:0][NUM_CMP-1:0] route_map;
  logic [NUM_OUT-1:0]              trig;
  logic [NUM_OUT-1:0]              pulse;
  pcmp_cfg_t                       cfg;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] pcmp_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  sel
  );
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        r[8*b +: 8] = new_v[8*b +: 8];
    end
    return r;
  endfunction : pcmp_merge

  // ****************************************************************
  // Address decode and read mux
  // ****************************************************************
  assign access   = wb_cyc_i && wb_stb_i && !s.ack;
  assign word_adr = {wb_adr_i[7:2], 2'b00};
  assign cmp_hit  = (word_adr >= OFS_CMP_BASE) && (word_adr <= OFS_CMP_LAST);
  assign cmp_idx  = word_adr[4:2];

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (cmp_hit)
      rd_mux = s.cmp[cmp_idx];
    else
    begin
      unique case (word_adr)
        OFS_CTRL:
        begin
          rd_mux[CTRL_INH_BIT] = s.inhibit;
          rd_mux[CTRL_DIR_LSB +: 2] = s.dir;
        end
        OFS_WIDTH:
          rd_mux = s.width;
        OFS_COMP:
          rd_mux = {{16{s.comp[15]}}, s.comp};
        OFS_ROUTE:
          rd_mux = s.route;
        OFS_STATUS:
        begin
          rd_mux[NUM_OUT-1:0] = pulse;
          rd_mux[STAT_PRIMED] = s.primed;
        end
        default:
          rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // Lead correction
  // ****************************************************************
  // Fixed update period trades a divider for a shift
  always_comb
  begin
    lead = $signed({1'b0, ENC_LATENCY_TENTHS})
         + $signed({s.comp[15], s.comp});
    prod = $signed(s.speed) * lead;
    corr = prod >>> UPD_SHIFT;
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    next_s = s;
    next_s.ack = 1'b0;
    next_s.pred_valid = 1'b0;
    if (access)
    begin
      next_s.ack = 1'b1;
      next_s.rdata = rd_mux;
      if (wb_we_i)
      begin
        if (cmp_hit)
          next_s.cmp[cmp_idx] = pcmp_merge(s.cmp[cmp_idx], wb_dat_i,
                                           wb_sel_i);
        else
        begin
          unique case (word_adr)
            OFS_CTRL:
            begin
              if (wb_sel_i[0])
              begin
                next_s.inhibit = wb_dat_i[CTRL_INH_BIT];
                next_s.dir = pcmp_dir_t'(wb_dat_i[CTRL_DIR_LSB +: 2]);
              end
            end
            OFS_WIDTH:
              next_s.width = pcmp_merge(s.width, wb_dat_i, wb_sel_i);
            OFS_COMP:
            begin
              if (wb_sel_i[0])
                next_s.comp[7:0] = wb_dat_i[7:0];
              if (wb_sel_i[1])
                next_s.comp[15:8] = wb_dat_i[15:8];
            end
            OFS_ROUTE:
              next_s.route = pcmp_merge(s.route, wb_dat_i, wb_sel_i);
            default:
              next_s.route = s.route;
          endcase
        end
      end
    end
    if (pos_valid)
    begin
      next_s.prev_pos = pos_actual;
      next_s.primed = 1'b1;
      // First sample after reset has no valid predecessor
      if (s.primed)
        next_s.speed = pos_actual - s.prev_pos;
      else
        next_s.speed = 32'h0000_0000;
      next_s.pred = pos_actual + corr[31:0];
      next_s.pred_valid = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s <= '0;
      s.width <= RST_WIDTH;
      s.comp <= RST_COMP;
      s.route <= RST_ROUTE;
      s.cmp <= {NUM_CMP{RST_CMP}};
      s.dir <= DIR_BOTH;
    end
    else
      s <= next_s;
  end

  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.rdata;
  assign compare_pulse_output = pulse;
  assign cfg = '{inhibit: s.inhibit, dir: s.dir};

  // ****************************************************************
  // Per value crossing detection
  // ****************************************************************
  generate
    for (genvar i = 0; i < NUM_CMP; i++)
    begin : g_cmp
      logic [ROUTE_W-1:0] code;
      assign code = s.route[ROUTE_W*i +: ROUTE_W];
      pcmp_cross u_cross (
        .sys_clk    (sys_clk),
        .arst_n     (arst_n),
        .pred_valid (s.pred_valid),
        .pred_pos   ($signed(s.pred)),
        .cmp_value  ($signed(s.cmp[i])),
        .enable     ((code != 4'h0) && (code <= 4'h3)),
        .cfg        (cfg),
        .hit        (hit[i])
      );
      for (genvar k = 0; k < NUM_OUT; k++)
      begin : g_map
        assign route_map[k][i] = (code == 4'(k + 1));
      end
    end
  endgenerate

  // ****************************************************************
  // Per output pulse stretchers
  // ****************************************************************
  generate
    for (genvar k = 0; k < NUM_OUT; k++)
    begin : g_out
      assign trig[k] = |(hit & route_map[k]);
      pcmp_pulse u_pulse (
        .sys_clk   (sys_clk),
        .arst_n    (arst_n),
        .trig      (trig[k]),
        .width     (s.width),
        .pulse_out (pulse[k])
      );
    end
  endgenerate

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_ack_once;
    @(posedge sys_clk) disable iff (!arst_n)
    s.ack |=> !s.ack;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack held longer than one cycle");

  property p_route_out;
    @(posedge sys_clk) disable iff (!arst_n)
    (|(hit & route_map[0])) && s.width != 32'h0000_0000
      |=> compare_pulse_output[0];
  endproperty
  a_route_out: assert property (p_route_out)
    else $error("routed hit gave no pulse");

  property p_route_off;
    @(posedge sys_clk) disable iff (!arst_n)
    s.route[3:0] == 4'h0 |=> !hit[0];
  endproperty
  a_route_off: assert property (p_route_off)
    else $error("disabled value produced a hit");

  property p_pred_still;
    @(posedge sys_clk) disable iff (!arst_n)
    pos_valid && s.speed == 32'h0000_0000
      |=> s.pred == $past(pos_actual) && s.pred_valid;
  endproperty
  a_pred_still: assert property (p_pred_still)
    else $error("prediction moved with zero speed");

endmodule : pcmp_top

// File: rtl/pcmp_pkg.sv
// Constants, register map and carrier types of the position compare block.
// Assumes a single 100 MHz clock and a classic Wishbone register port.
package pcmp_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_CMP = 8;
  localparam int NUM_OUT = 3;
  localparam int ROUTE_W = 4;

  // ****************************************************************
  // Register map, byte addresses
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_WIDTH    = 8'h04;
  localparam logic [7:0] OFS_COMP     = 8'h08;
  localparam logic [7:0] OFS_ROUTE    = 8'h0C;
  localparam logic [7:0] OFS_STATUS   = 8'h10;
  localparam logic [7:0] OFS_CMP_BASE = 8'h20;
  localparam logic [7:0] OFS_CMP_LAST = 8'h3C;

  localparam int CTRL_INH_BIT = 0;
  localparam int CTRL_DIR_LSB = 1;
  localparam int STAT_PRIMED  = 3;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [31:0] RST_WIDTH = 32'h0000_0064;
  localparam logic [15:0] RST_COMP  = 16'h0000;
  localparam logic [31:0] RST_ROUTE = 32'h0000_0000;
  localparam logic [31:0] RST_CMP   = 32'h0000_0000;

  // ****************************************************************
  // Timing of the lead correction
  // ****************************************************************
  // Update period assumed 2**UPD_SHIFT tenths of a microsecond
  localparam int          UPD_SHIFT         = 10;
  localparam logic [15:0] ENC_LATENCY_TENTHS = 16'h0064;

  // ****************************************************************
  // Codes and carriers
  // ****************************************************************
  typedef enum logic [1:0] {
    DIR_BOTH = 2'b00,
    DIR_POS  = 2'b01,
    DIR_NEG  = 2'b10
  } pcmp_dir_t;

  typedef enum logic [1:0] {
    REL_LT = 2'b00,
    REL_EQ = 2'b01,
    REL_GT = 2'b10
  } pcmp_rel_t;

  typedef struct packed {
    logic      inhibit;
    pcmp_dir_t dir;
  } pcmp_cfg_t;

endpackage : pcmp_pkg

// File: rtl/pcmp_cross.sv
// One comparison value: relation tracking and crossing detection.
// Assumes pred_valid is a one-cycle strobe on the same clock.
`timescale 1ns/1ps
module pcmp_cross
  import pcmp_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               arst_n,
  input  wire logic               pred_valid,
  input  wire logic signed [31:0] pred_pos,
  input  wire logic signed [31:0] cmp_value,
  input  wire logic               enable,
  input  wire pcmp_cfg_t          cfg,
  output logic                    hit
);
  typedef struct packed {
    pcmp_rel_t rel;
    logic      primed;
    logic      hit;
  } pcmp_cross_t;

  pcmp_cross_t s;
  pcmp_cross_t next_s;
  pcmp_rel_t   cur;
  logic        dir_ok;

  always_comb
  begin
    next_s = s;
    next_s.hit = 1'b0;
    // Signed relation on each update
    if (pred_pos > cmp_value)
      cur = REL_GT;
    else if (pred_pos < cmp_value)
      cur = REL_LT;
    else
      cur = REL_EQ;
    unique case (cfg.dir)
      DIR_BOTH: dir_ok = 1'b1;
      DIR_POS:  dir_ok = (s.rel == REL_LT);
      DIR_NEG:  dir_ok = (s.rel == REL_GT);
      default:  dir_ok = 1'b1;
    endcase
    if (!enable)
      next_s.primed = 1'b0;
    else if (pred_valid)
    begin
      next_s.rel = cur;
      next_s.primed = 1'b1;
      // Leaving EQ gives nothing: a stop on the value already fired
      next_s.hit = s.primed && (cur != s.rel) && (s.rel != REL_EQ)
                   && dir_ok && !cfg.inhibit;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      s <= '{rel: REL_LT, primed: 1'b0, hit: 1'b0};
    else
      s <= next_s;
  end

  assign hit = s.hit;

  property p_hit_on_update;
    @(posedge sys_clk) disable iff (!arst_n)
    s.hit |-> $past(pred_valid) && $past(enable);
  endproperty
  a_hit_on_update: assert property (p_hit_on_update)
    else $error("hit without a position update");

  property p_inhibit;
    @(posedge sys_clk) disable iff (!arst_n)
    cfg.inhibit |=> !s.hit;
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("hit while inhibited");

  property p_rest_once;
    @(posedge sys_clk) disable iff (!arst_n)
    pred_valid && s.primed && s.rel == REL_EQ && cur == REL_EQ |=> !s.hit;
  endproperty
  a_rest_once: assert property (p_rest_once)
    else $error("repeat hit at rest");

  property p_dir_pos;
    @(posedge sys_clk) disable iff (!arst_n)
    pred_valid && s.primed && enable && !cfg.inhibit && cfg.dir == DIR_POS
      && s.rel == REL_LT && cur == REL_GT |=> s.hit;
  endproperty
  a_dir_pos: assert property (p_dir_pos)
    else $error("positive crossing missed");

endmodule : pcmp_cross

// File: rtl/pcmp_pulse.sv
// Retriggerable pulse stretcher for one compare output.
// Assumes trig is a one-cycle strobe on the same clock; width in cycles.
`timescale 1ns/1ps
module pcmp_pulse
  import pcmp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        trig,
  input  wire logic [31:0] width,
  output logic             pulse_out
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        out;
    logic [31:0] since;
    logic [31:0] wl;
  } pcmp_pulse_t;

  pcmp_pulse_t s;
  pcmp_pulse_t next_s;

  always_comb
  begin
    next_s = s;
    if (trig)
    begin
      next_s.cnt = width;
      next_s.wl = width;
      next_s.since = 32'h0000_0001;
    end
    else
    begin
      // Running pulse finishes even when new hits are inhibited
      if (s.cnt != 32'h0000_0000)
        next_s.cnt = s.cnt - 32'h0000_0001;
      if (s.since != 32'hFFFF_FFFF)
        next_s.since = s.since + 32'h0000_0001;
    end
    next_s.out = (next_s.cnt != 32'h0000_0000);
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign pulse_out = s.out;

  sequence s_fire;
    trig && width != 32'h0000_0000;
  endsequence
  sequence s_on;
    pulse_out && s.since == 32'h0000_0001;
  endsequence

  property p_start;
    @(posedge sys_clk) disable iff (!arst_n)
    s_fire |=> s_on;
  endproperty
  a_start: assert property (p_start)
    else $error("pulse did not start on trigger");

  property p_width;
    @(posedge sys_clk) disable iff (!arst_n)
    $fell(pulse_out) |-> s.since == s.wl + 32'h0000_0001;
  endproperty
  a_width: assert property (p_width)
    else $error("pulse width wrong");

  property p_hold;
    @(posedge sys_clk) disable iff (!arst_n)
    pulse_out && s.since < s.wl && !trig |=> pulse_out;
  endproperty
  a_hold: assert property (p_hold)
    else $error("pulse cut short");

endmodule : pcmp_pulse

// File: tb/pcmp_camera.sv
// Model of the triggered equipment: one exposure counter per compare output.
// Assumes the outputs are active-high levels on sys_clk.
`timescale 1ns/1ps
module pcmp_camera
  import pcmp_pkg::*;
(
  input  wire logic                     sys_clk,
  input  wire logic                     arst_n,
  input  wire logic [NUM_OUT-1:0]       trig,
  output logic      [NUM_OUT-1:0]       shot_done,
  output logic      [NUM_OUT-1:0][15:0] shot_len
);
  // ****************************************************************
  // Exposure length measurement
  // ****************************************************************
  logic [NUM_OUT-1:0][15:0] run_cnt;

  // Length reported one cycle after the trigger falls, so a
  // retriggered pulse shows up as one long exposure
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      run_cnt   <= '0;
      shot_done <= '0;
      shot_len  <= '0;
    end
    else
    begin
      for (int k = 0; k < NUM_OUT; k++)
      begin
        shot_done[k] <= 1'b0;
        if (trig[k])
          run_cnt[k] <= run_cnt[k] + 16'h0001;
        else if (run_cnt[k] != 16'h0000)
        begin
          shot_done[k] <= 1'b1;
          shot_len[k]  <= run_cnt[k];
          run_cnt[k]   <= 16'h0000;
        end
      end
    end
  end
endmodule : pcmp_camera

// File: tb/testbench.sv
// Self-checking bench: Wishbone set-up and position sweeps of the block.
// Assumes pcmp_camera as the triggered equipment on the outputs.
`timescale 1ns/1ps
module testbench
  import pcmp_pkg::*;
;
  logic                     sys_clk;
  logic                     arst_n;
  logic                     wb_cyc_i;
  logic                     wb_stb_i;
  logic                     wb_we_i;
  logic [7:0]               wb_adr_i;
  logic [3:0]               wb_sel_i;
  logic [31:0]              wb_dat_i;
  logic [31:0]              wb_dat_o;
  logic                     wb_ack_o;
  logic                     pos_valid;
  logic signed [31:0]       pos_actual;
  logic [NUM_OUT-1:0]       pulse;
  logic [NUM_OUT-1:0]       shot_done;
  logic [NUM_OUT-1:0][15:0] shot_len;
  int                       error_cnt;
  int                       comparisons;
  int                       w;
  logic [31:0]              rd_q[$];
  int                       len_q[NUM_OUT][$];

  localparam logic [7:0]  RST_ADR [8] = '{OFS_CTRL, OFS_WIDTH, OFS_COMP,
    OFS_ROUTE, OFS_STATUS, OFS_CMP_BASE, OFS_CMP_LAST, 8'h14};
  localparam logic [31:0] RST_VAL [8] = '{32'h0, RST_WIDTH, 32'h0,
    RST_ROUTE, 32'h0, RST_CMP, RST_CMP, 32'h0};

  pcmp_top dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pos_valid(pos_valid), .pos_actual(pos_actual),
    .compare_pulse_output(pulse));
  pcmp_camera cam_u (.sys_clk(sys_clk), .arst_n(arst_n), .trig(pulse),
    .shot_done(shot_done), .shot_len(shot_len));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ****************************************************************
  // Checking and reporting
  // ****************************************************************
  task automatic final_report();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  task automatic chk_reg(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_reg

  task automatic chk_len(input string what, input int exp,
                         input logic [15:0] got);
    comparisons++;
    if (got !== exp[15:0])
    begin
      error_cnt++;
      $display("FAIL %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_len

  // Results are matched against the oldest note as they appear
  always @(posedge sys_clk)
  begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rd_q.size() > 0)
      chk_reg("read data", rd_q.pop_front(), wb_dat_o);
    for (int k = 0; k < NUM_OUT; k++)
      if (shot_done[k] === 1'b1)
      begin
        if (len_q[k].size() == 0)
          chk_len("unexpected pulse", 0, shot_len[k]);
        else
          chk_len("pulse length", len_q[k].pop_front(), shot_len[k]);
      end
  end

  // ****************************************************************
  // Drivers
  // ****************************************************************
  task automatic wb_cycle(input logic we, input logic [7:0] adr,
                          input logic [3:0] sel, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= d;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1)
    begin
      error_cnt++;
      $display("FAIL bus ack expected 1 seen %b", wb_ack_o);
      final_report();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb_cycle

  task automatic wb_write(input logic [7:0] adr, input logic [3:0] sel,
                          input logic [31:0] d);
    wb_cycle(1'b1, adr, sel, d);
  endtask : wb_write

  task automatic wb_read(input logic [7:0] adr, input logic [31:0] exp);
    rd_q.push_back(exp);
    wb_cycle(1'b0, adr, 4'hF, 32'h0);
  endtask : wb_read

  // One position update, noting a pulse of width w on each output in m
  task automatic step(input logic signed [31:0] p, input int gap,
                      input logic [NUM_OUT-1:0] m);
    for (int k = 0; k < NUM_OUT; k++)
      if (m[k])
        len_q[k].push_back(w);
    @(posedge sys_clk);
    pos_valid  <= 1'b1;
    pos_actual <= p;
    @(posedge sys_clk);
    pos_valid <= 1'b0;
    repeat (gap) @(posedge sys_clk);
  endtask : step

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    error_cnt   = 0;
    comparisons = 0;
    arst_n      = 1'b0;
    wb_cyc_i    = 1'b0;
    wb_stb_i    = 1'b0;
    wb_we_i     = 1'b0;
    wb_adr_i    = 8'h00;
    wb_sel_i    = 4'h0;
    wb_dat_i    = 32'h0;
    pos_valid   = 1'b0;
    pos_actual  = 32'sh0;
    w           = $urandom(97);
    w           = 10 + ($urandom % 20);
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    foreach (RST_ADR[i])
      wb_read(RST_ADR[i], RST_VAL[i]);
    wb_write(8'h14, 4'hF, 32'hDEAD_BEEF);
    wb_read(8'h14, 32'h0);
    wb_write(OFS_WIDTH, 4'h1, {24'hAAAAAA, w[7:0]});
    wb_read(OFS_WIDTH, 32'(w));
    // Minus 100 cancels the lead, so the compared position is exact
    wb_write(OFS_COMP, 4'h3, 32'h1234_FF9C);
    wb_read(OFS_COMP, 32'hFFFF_FF9C);
    wb_write(OFS_CMP_BASE, 4'hF, 32'd1000);
    wb_write(OFS_CMP_BASE + 8'h04, 4'hF, 32'd2000);
    wb_write(OFS_CMP_BASE + 8'h08, 4'hF, -32'sd500);
    wb_write(OFS_CMP_BASE + 8'h0C, 4'hF, 32'd5000);
    wb_write(OFS_ROUTE, 4'hF, 32'h0007_3211);
    step(0, 3, 3'b000);
    wb_read(OFS_STATUS, 32'h8);
    step(32'sd1001 + 32'($urandom % 900), 40, 3'b001);
    step(2500, 40, 3'b001);
    step(-1000, 40, 3'b011);
    len_q[0].push_back(w + 10);
    step(1500, 8, 3'b010);
    step(500, 40, 3'b000);
    step(4000, 40, 3'b001);
    step(5000, 40, 3'b100);
    step(5000, 10, 3'b000);
    step(5000, 10, 3'b000);
    step(6000, 40, 3'b000);
    for (int d = 0; d < 4; d++)
    begin
      wb_write(OFS_CTRL, 4'hF, 32'(d << CTRL_DIR_LSB));
      step(4000, 40, (d == 1) ? 3'b000 : 3'b100);
      step(6000, 40, (d == 2) ? 3'b000 : 3'b100);
    end
    wb_write(OFS_CTRL, 4'hF, 32'h0);
    step(4000, 4, 3'b100);
    wb_write(OFS_CTRL, 4'hF, 32'h1);
    step(6000, 40, 3'b000);
    step(4000, 40, 3'b000);
    wb_write(OFS_CTRL, 4'hF, 32'h0);
    step(6000, 40, 3'b100);
    // Steady 100 per update, then a lead of exactly one update
    step(4000, 40, 3'b100);
    for (int p = 4100; p <= 4400; p += 100)
      step(p, 2, 3'b000);
    wb_write(OFS_COMP, 4'hF, 32'h0000_039C);
    for (int p = 4500; p <= 4800; p += 100)
      step(p, 5, 3'b000);
    chk_reg("level before lead", 32'h0, 32'(pulse));
    step(4900, 5, 3'b100);
    chk_reg("level on lead", 32'h4, 32'(pulse));
    // Status shows the running output level and the primed flag
    wb_read(OFS_STATUS, 32'hC);
    step(5000, 40, 3'b000);
    repeat (60) @(posedge sys_clk);
    for (int k = 0; k < NUM_OUT; k++)
      chk_len("missing pulses", 0, 16'(len_q[k].size()));
    final_report();
  end
endmodule : testbench
